// file: rtl/tsr_pkg.sv
// Shared constants of the temperature sensor register bank
package tsr_pkg;
  // Pointer decode, low three bits of the pointer byte
  localparam logic [2:0] PTR_TEMP = 3'h0;
  localparam logic [2:0] PTR_CFG = 3'h1;
  localparam logic [2:0] PTR_LOW = 3'h2;
  localparam logic [2:0] PTR_HIGH = 3'h3;
  localparam logic [2:0] PTR_ONESHOT = 3'h4;
  // Values after reset
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] LOW_RESET = 16'h4b00;
  localparam logic [15:0] HIGH_RESET = 16'h5000;
  // Configuration field positions, upper byte of the word
  localparam int CFG_OS_BIT = 13;
  localparam int CFG_FQ_LSB = 11;
  localparam int CFG_POL_BIT = 10;
  localparam int CFG_TM_BIT = 9;
  localparam int CFG_SD_BIT = 8;
  // 12-bit result sits in bits 15 down to 4
  localparam int RES_LSB = 4;
  // Conversion timing
  localparam int CLK_KHZ = 200000;
  localparam int CONV_TIME_MS = 27;
  localparam int PERIOD_MS = 80;
  localparam int CONV_CYC = CONV_TIME_MS * CLK_KHZ;
  localparam int PERIOD_CYC = PERIOD_MS * CLK_KHZ;
  // Two-wire slave address, value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;
endpackage

// file: rtl/tsr_conv_timer.sv
// Conversion sequencer: continuous, one-shot and shutdown timing
`timescale 1ns/1ps
module tsr_conv_timer import tsr_pkg::*; #(
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int PERIOD_CYCLES = PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic shut,
  input wire logic cont_en,
  input wire logic os_kick,
  output logic busy,
  output logic conv_done
);
  localparam int CW = $clog2(PERIOD_CYCLES + 1);
  localparam logic [CW-1:0] CONV_M1 = CW'(CONV_CYCLES - 1);
  localparam logic [CW-1:0] PER_M1 = CW'(PERIOD_CYCLES - 1);

  logic [CW-1:0] cnt_r;
  wire period_up = cont_en && (cnt_r == PER_M1);

  // ****************************************
  // Sequencer
  // ****************************************
  // Busy out of reset: the first conversion starts at power-up
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b1;
      cnt_r <= '0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (shut) begin
        busy <= 1'b0;
        cnt_r <= PER_M1;
      end else if (busy) begin
        if (cnt_r == CONV_M1) begin
          busy <= 1'b0;
          conv_done <= 1'b1;
        end
        cnt_r <= cnt_r + 1'b1;
      end else if (period_up || os_kick) begin
        busy <= 1'b1;
        cnt_r <= '0;
      end else if (cont_en) begin
        cnt_r <= cnt_r + 1'b1;
      end else begin
        cnt_r <= PER_M1;
      end
    end
  end
endmodule

// file: rtl/tsr_twowire.sv
// Two-wire slave front end: pointer byte, data bytes, word reads
`timescale 1ns/1ps
module tsr_twowire import tsr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_out,
  output logic sda_oe,
  output logic ptr_wr,
  output logic [7:0] ptr_val,
  output logic byte_wr,
  output logic byte_lsb,
  output logic [7:0] byte_val,
  output logic rd_start,
  input wire logic [15:0] rd_word
);
  typedef enum {TW_IDLE, TW_ADDR, TW_ACK, TW_PTR, TW_WR, TW_RD, TW_RACK} tsr_tw_e;
  tsr_tw_e st_r, next_r;
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic ph_r, wlsb_r, rlsb_r, racked_r;
  logic [15:0] rword_r;

  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire bus_start = scl_s && scl_d && sda_d && !sda_s;
  wire bus_stop = scl_s && scl_d && !sda_d && sda_s;
  wire [7:0] rx_byte = {sh_r[6:0], sda_s};
  wire last_bit = (bit_r == 4'd7);
  wire [7:0] rd_next = rlsb_r ? rword_r[7:0] : rword_r[15:8];

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {scl_m, scl_s, scl_d} <= 3'b111;
      {sda_m, sda_s, sda_d} <= 3'b111;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_pin, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_pin, sda_m, sda_s};
    end
  end

  // ****************************************
  // Byte engine
  // ****************************************
  // Open drain: only ever pulls low, so the data output stays 0
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= TW_IDLE;
      next_r <= TW_IDLE;
      bit_r <= '0;
      sh_r <= '0;
      {ph_r, wlsb_r, rlsb_r, racked_r} <= 4'b0000;
      rword_r <= '0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      {ptr_wr, byte_wr, byte_lsb, rd_start} <= 4'b0000;
      ptr_val <= '0;
      byte_val <= '0;
    end else begin
      {ptr_wr, byte_wr, rd_start} <= 3'b000;
      if (bus_start) begin
        st_r <= TW_ADDR;
        bit_r <= '0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        st_r <= TW_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (st_r)
          TW_IDLE: ;
          TW_ADDR, TW_PTR, TW_WR: if (scl_rise) begin
            sh_r <= rx_byte;
            bit_r <= bit_r + 4'd1;
            if (last_bit) begin
              st_r <= TW_ACK;
              ph_r <= 1'b0;
              if (st_r == TW_ADDR) begin
                next_r <= rx_byte[0] ? TW_RD : TW_PTR;
                wlsb_r <= 1'b0;
                rlsb_r <= 1'b0;
                rword_r <= rd_word;
                // A read aimed at another device must not clear the flag
                rd_start <= rx_byte[0] && (rx_byte[7:1] == DEV_ADDR);
                if (rx_byte[7:1] != DEV_ADDR) st_r <= TW_IDLE;
              end else if (st_r == TW_PTR) begin
                next_r <= TW_WR;
                ptr_wr <= 1'b1;
                ptr_val <= rx_byte;
              end else begin
                next_r <= TW_WR;
                byte_wr <= 1'b1;
                byte_lsb <= wlsb_r;
                byte_val <= rx_byte;
                wlsb_r <= 1'b1;
              end
            end
          end
          TW_ACK: if (scl_fall) begin
            ph_r <= 1'b1;
            sda_oe <= !ph_r;
            if (ph_r) begin
              st_r <= next_r;
              bit_r <= '0;
              if (next_r == TW_RD) begin
                sh_r <= rd_next;
                sda_oe <= !rd_next[7];
              end
            end
          end
          TW_RD: if (scl_rise) begin
            bit_r <= bit_r + 4'd1;
          end else if (scl_fall) begin
            sh_r <= {sh_r[6:0], 1'b0};
            sda_oe <= !sh_r[6];
            if (bit_r == 4'd8) begin
              sda_oe <= 1'b0;
              st_r <= TW_RACK;
              ph_r <= 1'b0;
              rlsb_r <= !rlsb_r;
            end
          end
          TW_RACK: if (scl_rise) begin
            racked_r <= !sda_s;
            ph_r <= 1'b1;
          end else if (scl_fall && ph_r) begin
            st_r <= racked_r ? TW_RD : TW_IDLE;
            bit_r <= '0;
            sh_r <= rd_next;
            sda_oe <= racked_r && !rd_next[7];
          end
        endcase
      end
    end
  end
endmodule

// file: rtl/tsr_top.sv
// Temperature sensor register bank, mode control and alert flag
`timescale 1ns/1ps
// ****************************************
// ****************************************
module tsr_top import tsr_pkg::*; #(
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int PERIOD_CYCLES = PERIOD_CYC,
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_out,
  output logic sda_oe,
  output logic alert_out,
  output logic alert_oe,
  output logic conv_busy,
  input wire logic [11:0] adc_code
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0] ptr_r;
  logic [11:0] temp_r, low_r, high_r;
  logic os_r, pol_r, tm_r, sd_r;
  logic [1:0] fq_r;
  logic [11:0] adc_m, adc_s;
  logic alert_r, await_cold_r;
  logic [2:0] fcnt_r;
  logic ptr_wr, byte_wr, byte_lsb, rd_start, conv_done, busy;
  logic [7:0] ptr_val, byte_val;
  logic [15:0] rd_word;

  function automatic logic [2:0] fq_need(input logic [1:0] code);
    unique case (code)
      2'd0: fq_need = 3'd1;
      2'd1: fq_need = 3'd2;
      2'd2: fq_need = 3'd4;
      2'd3: fq_need = 3'd6;
    endcase
  endfunction

  function automatic logic [15:0] res_word(input logic [11:0] v);
    res_word = {v, 4'h0};
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  wire [2:0] ptr_sel = ptr_r[2:0];
  wire wr_msb = byte_wr && !byte_lsb;
  wire wr_lsb = byte_wr && byte_lsb;
  wire wr_cfg = wr_msb && (ptr_sel == PTR_CFG);
  wire os_write = byte_wr && (ptr_sel == PTR_ONESHOT);
  wire os_kick = os_write && os_r && !sd_r;
  wire cont_en = !sd_r && !os_r;
  wire [15:0] cfg_word = {2'b00, os_r, fq_r, pol_r, tm_r, sd_r, 8'h00};
  wire hot = $signed(adc_s) >= $signed(high_r);
  wire cold = $signed(adc_s) < $signed(low_r);
  wire trip_hot = tm_r ? !await_cold_r : !alert_r;
  wire fault_hit = trip_hot ? hot : cold;
  wire [2:0] fcnt_inc = fcnt_r + 3'd1;
  wire reached = fault_hit && (fcnt_inc >= fq_need(fq_r));
  wire pin_level = pol_r ? alert_r : !alert_r;

  always_comb begin
    unique case (ptr_sel)
      PTR_TEMP: rd_word = res_word(temp_r);
      PTR_CFG: rd_word = cfg_word;
      PTR_LOW: rd_word = res_word(low_r);
      PTR_HIGH: rd_word = res_word(high_r);
      default: rd_word = 16'h0000;
    endcase
  end

  // ****************************************
  // Sub-blocks
  // ****************************************
  tsr_twowire #(.DEV_ADDR(DEV_ADDR)) u_link (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .ptr_wr(ptr_wr),
    .ptr_val(ptr_val),
    .byte_wr(byte_wr),
    .byte_lsb(byte_lsb),
    .byte_val(byte_val),
    .rd_start(rd_start),
    .rd_word(rd_word)
  );

  tsr_conv_timer #(.CONV_CYCLES(CONV_CYCLES), .PERIOD_CYCLES(PERIOD_CYCLES)) u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .shut(sd_r),
    .cont_en(cont_en),
    .os_kick(os_kick),
    .busy(busy),
    .conv_done(conv_done)
  );

  // ****************************************
  // Registers
  // ****************************************
  // Converter output is slow-moving; double-registered every clock, taken into the result at conversion end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      adc_m <= '0;
      adc_s <= '0;
    end else begin
      adc_m <= adc_code;
      adc_s <= adc_m;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ptr_r <= PTR_RESET;
      temp_r <= TEMP_RESET[15:RES_LSB];
      {os_r, fq_r, pol_r, tm_r, sd_r} <= CFG_RESET[CFG_OS_BIT:CFG_SD_BIT];
      low_r <= LOW_RESET[15:RES_LSB];
      high_r <= HIGH_RESET[15:RES_LSB];
    end else begin
      if (ptr_wr) ptr_r <= ptr_val;
      if (conv_done) temp_r <= adc_s;
      if (wr_cfg) begin
        // Reserved bits 15:14 are dropped whatever the host sends
        os_r <= byte_val[CFG_OS_BIT-8];
        fq_r <= byte_val[CFG_FQ_LSB-7:CFG_FQ_LSB-8];
        pol_r <= byte_val[CFG_POL_BIT-8];
        tm_r <= byte_val[CFG_TM_BIT-8];
        sd_r <= byte_val[CFG_SD_BIT-8];
      end
      if (wr_msb && ptr_sel == PTR_LOW) low_r[11:4] <= byte_val;
      if (wr_lsb && ptr_sel == PTR_LOW) low_r[3:0] <= byte_val[7:4];
      if (wr_msb && ptr_sel == PTR_HIGH) high_r[11:4] <= byte_val;
      if (wr_lsb && ptr_sel == PTR_HIGH) high_r[3:0] <= byte_val[7:4];
    end
  end

  // ****************************************
  // Fault queue and alert flag
  // ****************************************
  // Interrupt mode: a read clears the flag, but a trip in the same cycle wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      alert_r <= 1'b0;
      await_cold_r <= 1'b0;
      fcnt_r <= '0;
    end else if (sd_r) begin
      alert_r <= 1'b0;
      await_cold_r <= 1'b0;
      fcnt_r <= '0;
    end else begin
      if (tm_r && rd_start) alert_r <= 1'b0;
      if (conv_done) begin
        fcnt_r <= (fault_hit && !reached) ? fcnt_inc : 3'd0;
        if (reached && tm_r) begin
          alert_r <= 1'b1;
          await_cold_r <= !await_cold_r;
        end else if (reached) begin
          alert_r <= !alert_r;
        end
      end
    end
  end

  // Open drain flag pin: pulled low when its level is low
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      alert_out <= 1'b0;
      alert_oe <= 1'b0;
      conv_busy <= 1'b0;
    end else begin
      alert_out <= 1'b0;
      alert_oe <= !pin_level;
      conv_busy <= busy;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_result_update;
    conv_done |=> temp_r == $past(adc_s);
  endproperty
  a_result_update: assert property (p_result_update) else $error("result not updated");

  property p_result_ro;
    (byte_wr && ptr_sel == PTR_TEMP && !conv_done) |=> $stable(temp_r);
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("result changed by write");

  property p_shut_clears;
    sd_r |=> !alert_r && fcnt_r == 3'd0 && !busy;
  endproperty
  a_shut_clears: assert property (p_shut_clears) else $error("shutdown left state");

  property p_os_blocked;
    (sd_r && os_write) |=> !busy;
  endproperty
  a_os_blocked: assert property (p_os_blocked) else $error("conversion in shutdown");

  property p_os_start;
    (os_kick && !busy) |=> busy;
  endproperty
  a_os_start: assert property (p_os_start) else $error("one-shot did not start");

  property p_low_nibble;
    ptr_sel != PTR_CFG |-> rd_word[3:0] == 4'h0;
  endproperty
  a_low_nibble: assert property (p_low_nibble) else $error("reserved bits set");

  property p_cfg_low_byte;
    ptr_sel == PTR_CFG |-> rd_word[7:0] == 8'h00 && rd_word[15:14] == 2'b00;
  endproperty
  a_cfg_low_byte: assert property (p_cfg_low_byte) else $error("cfg reserved set");

  property p_high_msb;
    (wr_msb && ptr_sel == PTR_HIGH) |=> rd_word[15:8] == $past(byte_val)
      || ptr_sel != PTR_HIGH;
  endproperty
  a_high_msb: assert property (p_high_msb) else $error("high limit write lost");

  sequence s_hot_single;
    conv_done && hot && !alert_r && !tm_r && !sd_r && fq_r == 2'd0;
  endsequence

  property p_fq_one;
    s_hot_single |=> alert_r ##1 (alert_oe == !pol_r);
  endproperty
  a_fq_one: assert property (p_fq_one) else $error("single fault missed");

  property p_no_early;
    (conv_done && fq_r == 2'd3 && fcnt_r < 3'd4 && !alert_r && !tm_r) |=> !alert_r;
  endproperty
  a_no_early: assert property (p_no_early) else $error("flag before six faults");

  // Result only moves when a conversion ends
  property p_temp_hold;
    !conv_done |=> $stable(temp_r);
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("result moved");

  property p_ptr_load;
    ptr_wr |=> ptr_sel == $past(ptr_val[2:0]);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_low_lsb;
    (wr_lsb && ptr_sel == PTR_LOW) |=> rd_word[7:4] == $past(byte_val[7:4]);
  endproperty
  a_low_lsb: assert property (p_low_lsb) else $error("low limit write lost");

  sequence s_irq_read;
    tm_r && rd_start && !conv_done && !sd_r;
  endsequence

  property p_irq_clear;
    s_irq_read |=> !alert_r;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("read left flag set");

  sequence s_cold_sixth;
    conv_done && cold && alert_r && !tm_r && !sd_r && fq_r == 2'd3 && fcnt_r == 3'd5;
  endsequence

  property p_cold_six;
    s_cold_sixth |=> !alert_r;
  endproperty
  a_cold_six: assert property (p_cold_six) else $error("flag held after six cold");

  sequence s_os_finish;
    conv_done && os_r && !sd_r && !os_kick;
  endsequence

  property p_os_idle;
    s_os_finish |=> !busy;
  endproperty
  a_os_idle: assert property (p_os_idle) else $error("one-shot kept converting");
endmodule

// file: testbench/tsr_host_model.sv
// Two-wire bus master model for the sensor link
`timescale 1ns/1ps
module tsr_host_model (
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl = 1'b1,
  output logic sda_low = 1'b0
);
  // *****
  // Bit and byte level, 160 ns per bit
  // *****
  localparam int Q = 40;
  // SDA only moves while SCL is low, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda_line;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic start();
    @(posedge clk_sys);
    #1 sda_low = 1'b1;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask
  // Stop leaves both lines released; pull-ups hold them high
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_low = 1'b0;
    #(2*Q);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
  // *****
  // Transfers: pointer byte then n data bytes, MS first
  // *****
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
    input int n, output logic ok);
    logic k;
    start();
    put_byte({a, 1'b0}, ok);
    for (int i = 0; i <= n; i++) begin
      put_byte(i == 0 ? p : (i == 1 ? d[15:8] : d[7:0]), k);
      ok = ok & k;
    end
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d);
    logic k;
    wr(a, p, 16'h0000, 0, k);
    start();
    put_byte({a, 1'b1}, k);
    get_byte(1'b0, d[15:8]);
    get_byte(1'b1, d[7:0]);
    stop();
  endtask
endmodule

// file: testbench/tsr_top_tb_top.sv
// Self-checking bench for the sensor register bank
`timescale 1ns/1ps
`define CMP(n, e, g) if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, g); end
module tsr_top_tb_top import tsr_pkg::*;;
  // *****
  // Setup
  // *****
  localparam int CONV = 20;
  localparam int PER = 60;
  localparam logic [6:0] ADDR = 7'h2a;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] adc_code = 12'h000;
  logic scl, host_low, sda_oe, sda_out, alert_oe, alert_out, conv_busy, busy_q;
  wire logic sda_line = !(sda_oe | host_low);
  int err_count = 0;
  int samples_checked = 0;
  int rises = 0;
  logic [31:0] lfsr = 32'ha354;
  logic [15:0] exp_q[$];
  logic [15:0] got_q[$];
  string nm_q[$];
  always #2.5 clk_sys = !clk_sys;
  tsr_top #(.CONV_CYCLES(CONV), .PERIOD_CYCLES(PER), .DEV_ADDR(ADDR)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .scl_pin(scl), .sda_pin(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe), .conv_busy(conv_busy),
    .adc_code(adc_code));
  tsr_host_model host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(host_low));
  always @(posedge clk_sys) begin
    busy_q <= conv_busy;
    if (conv_busy === 1'b1 && busy_q === 1'b0) rises <= rises + 1;
  end
  initial begin : monitor
    logic [15:0] e;
    logic [15:0] g;
    string n;
    forever begin
      wait (got_q.size() > 0);
      e = exp_q.pop_front();
      g = got_q.pop_front();
      n = nm_q.pop_front();
      samples_checked++;
      `CMP(n, e, g)
    end
  end
  // *****
  // Shared tasks
  // *****
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] cfg(input logic os, input logic [1:0] fq, input logic flag_active_level,
    input logic tm, input logic sd);
    return {2'b00, os, fq, flag_active_level, tm, sd, 8'h00};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic pin_chk(input string n, input logic [15:0] e, input logic [15:0] g);
    nm_q.push_back(n);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] p, input logic [15:0] e);
    logic [15:0] d;
    nm_q.push_back(n);
    exp_q.push_back(e);
    host.rd(ADDR, p, d);
    got_q.push_back(d);
  endtask
  task automatic put_reg(input logic [7:0] p, input logic [15:0] d, input int n);
    logic ok;
    host.wr(ADDR, p, d, n, ok);
    pin_chk("ack", 16'h0001, {15'h0, ok});
  endtask
  // Bounded per conversion so a stalled timer cannot hang the run
  task automatic falls(input int n);
    repeat (n) begin
      for (int k = 0; k < PER && !conv_busy; k++) cyc(1);
      for (int k = 0; k < PER && conv_busy; k++) cyc(1);
    end
    cyc(4);
  endtask
  task automatic alert_chk(input logic act, input logic flag_active_level);
    pin_chk("alert_oe", {15'h0, flag_active_level ^ act}, {15'h0, alert_oe});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // *****
  // Scenarios
  // *****
  initial begin : main
    int hi;
    int lo;
    int r0;
    logic ok;
    repeat (2) @(posedge clk_sys);
    #1 rstn = 1'b1;
    cyc(3);
    rd_chk("temp", 8'h00, 16'h0000);
    rd_chk("cfg", 8'h01, 16'h0000);
    rd_chk("oneshot", 8'h04, 16'h0000);
    rd_chk("high", 8'hf3, 16'h5000);
    host.wr(ADDR ^ 7'h01, 8'h02, 16'h0000, 2, ok);
    pin_chk("nack", 16'h0000, {15'h0, ok});
    rd_chk("low", 8'h02, 16'h4b00);
    $display("reset and decode test done");
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      falls(1);
      adc_code = lfsr[11:0];
      falls(2);
      rd_chk("temp", 8'h00, {lfsr[11:0], 4'h0});
    end
    put_reg(8'h00, 16'hffff, 2);
    rd_chk("temp", 8'h00, {adc_code, 4'h0});
    lfsr = lfsr_next(lfsr);
    put_reg(8'h02, lfsr[15:0] | 16'h000f, 2);
    rd_chk("low", 8'h02, lfsr[15:0] & 16'hfff0);
    put_reg(8'h03, lfsr[31:16], 2);
    put_reg(8'h03, 16'h6000, 1);
    rd_chk("high", 8'h03, {8'h60, lfsr[23:20], 4'h0});
    put_reg(8'h02, 16'h4b00, 2);
    put_reg(8'h03, 16'h5000, 2);
    $display("result and limit test done");
    for (int q = 0; q < 4; q++) begin
      put_reg(8'h01, cfg(0, 2'(q), 1, 0, 1), 1);
      alert_chk(0, 1);
      adc_code = 12'h100;
      put_reg(8'h01, cfg(0, 2'(q), 1, 0, 0), 1);
      falls(1);
      adc_code = 12'h600;
      falls(q == 0 ? 0 : 2 * q - 1);
      alert_chk(0, 1);
      falls(1);
      alert_chk(1, 1);
    end
    put_reg(8'h01, cfg(0, 2'h3, 0, 0, 0), 1);
    alert_chk(1, 0);
    falls(1);
    adc_code = 12'h100;
    falls(5);
    alert_chk(1, 0);
    falls(1);
    alert_chk(0, 0);
    put_reg(8'h01, cfg(0, 2'h0, 1, 1, 1), 1);
    put_reg(8'h01, cfg(0, 2'h0, 1, 1, 0), 1);
    falls(1);
    adc_code = 12'h600;
    falls(1);
    alert_chk(1, 1);
    rd_chk("cfg", 8'h01, cfg(0, 2'h0, 1, 1, 0));
    alert_chk(0, 1);
    falls(2);
    alert_chk(0, 1);
    $display("alert test done");
    put_reg(8'h01, cfg(0, 2'h0, 1, 0, 0), 1);
    falls(1);
    for (int k = 0; k < PER && !conv_busy; k++) cyc(1);
    for (hi = 0; hi < PER && conv_busy; hi++) cyc(1);
    for (lo = 0; lo < PER && !conv_busy; lo++) cyc(1);
    pin_chk("conv_len", 16'(CONV), 16'(hi));
    pin_chk("idle_len", 16'(PER - CONV), 16'(lo));
    put_reg(8'h01, cfg(1, 2'h0, 1, 0, 1), 1);
    pin_chk("busy", 16'h0000, {15'h0, conv_busy});
    r0 = rises;
    put_reg(8'h04, 16'h0000, 1);
    cyc(100);
    pin_chk("starts", 16'(r0), 16'(rises));
    put_reg(8'h01, cfg(1, 2'h0, 1, 0, 0), 1);
    cyc(30);
    r0 = rises;
    adc_code = 12'h0a5;
    cyc(200);
    pin_chk("starts", 16'(r0), 16'(rises));
    put_reg(8'h04, 16'h5a00, 1);
    cyc(100);
    pin_chk("starts", 16'(r0 + 1), 16'(rises));
    rd_chk("temp", 8'h00, 16'h0a50);
    r0 = rises;
    put_reg(8'h01, cfg(0, 2'h0, 1, 0, 0), 1);
    pin_chk("resume", 16'h0001, 16'(rises > r0));
    pin_chk("pins", 16'h0000, {14'h0, sda_out, alert_out});
    $display("conversion mode test done");
    wait (got_q.size() == 0);
    #1;
    finish_test();
  end
  initial begin : watchdog
    #480000;
    err_count++;
    $display("BAD watchdog exp done got timeout");
    finish_test();
  end
endmodule
